// File: src/cpmc_regs.svh
// Register map, field positions, reset values and timing counts of the clock and power-mode controller
`ifndef CPMC_REGS_SVH
`define CPMC_REGS_SVH

// Register indices; the byte address is four times the index
`define CPMC_IDX_WDT_KICK 8'h86
`define CPMC_IDX_POWER_CTRL 8'h87
`define CPMC_IDX_MEM_WAIT 8'h8e
`define CPMC_IDX_P1_WAKE 8'h91
`define CPMC_IDX_CLK_DIV 8'he5
`define CPMC_IDX_CLK_APPLY 8'he6
`define CPMC_IDX_RST_CAUSE 8'he8
`define CPMC_IDX_SOFT_RST 8'he9
`define CPMC_IDX_CLK_STATUS 8'hf8

// Command codes
`define CPMC_KICK_CODE 8'h5a
`define CPMC_APPLY_CODE 8'h69

// Field positions
`define CPMC_RC_LVD_BIT 7
`define CPMC_RC_WDT_BIT 6
`define CPMC_RC_PIN_BIT 5
`define CPMC_RC_MID_BIT 2
`define CPMC_RC_HIGH_BIT 1
`define CPMC_SOFT_RESET_REQUEST_BIT 0
`define CPMC_PC_IDLE_BIT 0
`define CPMC_PC_STOP_BIT 1
`define CPMC_PC_GF0_BIT 2
`define CPMC_PC_P2SEL_BIT 3
`define CPMC_PC_SMOD_BIT 7
`define CPMC_MW_XWR_BIT 3

// Reset values
`define CPMC_RST_DIV 3'h7
`define CPMC_RST_FETCH_WAIT 3'h7
`define CPMC_RST_XRD_WAIT 3'h1
`define CPMC_RST_P2SEL 1'h1

// Warm-up counts in oscillator cycles and slow RC ticks
`define CPMC_WARM_LONG 12'h800
`define CPMC_WARM_SHORT 12'h040
`define CPMC_WARM_SLOW 12'h005

// Bus response codes
`define CPMC_RESP_OKAY 2'h0
`define CPMC_RESP_SLVERR 2'h2

`endif

// File: src/cpmc_pkg.sv
// Types shared by the clock and power-mode controller
package cpmc_pkg;

  // Oscillator source choice from the configuration option
  typedef enum logic [2:0] {
    CPMC_SRC_RC,
    CPMC_SRC_RC_RTC,
    CPMC_SRC_XTAL_HI,
    CPMC_SRC_XTAL_LO,
    CPMC_SRC_EXT
  } cpmc_src_t;

  // Power-mode sequencer states
  typedef enum logic [2:0] {
    CPMC_CFG,
    CPMC_WARM_OSC,
    CPMC_WARM_SLOW,
    CPMC_NORMAL,
    CPMC_IDLE,
    CPMC_STOP
  } cpmc_mode_t;

  // Oscillator pad configuration
  typedef struct packed {
    logic osc_in_gpio;
    logic osc_out_gpio;
    logic xtal_drive;
    logic rtc_clk_en;
  } cpmc_pad_t;

  // Whole controller state
  typedef struct packed {
    logic aw_have;
    logic [7:0] aw_idx;
    logic aw_ok;
    logic w_have;
    logic [7:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    cpmc_mode_t mode;
    logic [11:0] warm_cnt;
    cpmc_src_t src;
    logic [2:0] cause;
    logic soft_reset_request_armed;
    logic soft_rst;
    logic wdt_clr;
    logic [2:0] div_pend;
    logic [2:0] div_act;
    logic apply_pend;
    logic [6:0] div_cnt;
    logic cpu_tick;
    logic periph_tick;
    logic [2:0] fetch_wait;
    logic xwr_ext;
    logic [2:0] xrd_wait;
    logic smod;
    logic p2sel;
    logic gf0;
    logic stop;
    logic idle;
    logic [7:0] p1_wake;
    logic [7:0] p0_prev;
    logic [7:0] p1_prev;
    logic mem_busy;
    logic [3:0] mem_cnt;
    logic mem_ready;
  } cpmc_state_t;

endpackage

// File: src/cpmc_ctrl.sv
// Clock, power-mode and reset-status controller with its AXI4-Lite register slave
// Operation
// - Reset cause flags set by hardware, read-only
// - Live low-supply flags for 2.4 and 3.3 V
// - Two consecutive writes of one trigger reset
// - Writing 0x5A restarts the watchdog count
// - Oscillator source loaded during power-on sequence
// - Three-bit code divides oscillator 128 down to 1
// - Divider takes effect only on apply code
// - Program fetch stretched by fetch wait cycles
// - RC option frees both oscillator pins, external option only the output pin
// - RC with RTC drives 32.768 kHz crystal
// - Power control bit 0 idle, bit 1 stop
// - Idle gates only the CPU clock
// - Idle wakes on port change or interrupt
// - Stop halts CPU, peripherals and oscillator
// - Stop wakes only on port change
// - Reset warm-up 2048 fast plus 5 slow
// - Stop wake warm-up 2048 or 64 plus 5
// - After warm-up enter normal mode and run
// - Port 1 pin wakes only when enabled
// - External RAM reads stretched by read wait
// - External RAM writes extended when flag set
`timescale 1ns/10ps
`include "cpmc_regs.svh"

module cpmc_ctrl #(
  parameter int ADDR_W = 12,
  parameter int PORT_W = 8
) (
  // Clock and reset; aclk is the selected oscillator clock
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Configuration option and supply monitors
  input wire logic [2:0] clk_src_option,
  input wire logic vdd_below_mid_flag,
  input wire logic vdd_below_high_flag,
  // Reset-source events, one-cycle pulses
  input wire logic lvd_reset_event,
  input wire logic wdt_reset_event,
  input wire logic pin_reset_event,
  // Slow RC tick and wake sources
  input wire logic slow_rc_tick,
  input wire logic [PORT_W-1:0] port0_in,
  input wire logic [PORT_W-1:0] port1_in,
  input wire logic irq_event,
  // Memory access requests from the CPU
  input wire logic fetch_req,
  input wire logic external_data_ram_rd_req,
  input wire logic external_data_ram_wr_req,
  output logic mem_ready,
  // Clock enables and power outputs
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic osc_run,
  output logic cpu_hold,
  // Reset and watchdog requests
  output logic soft_reset_pulse,
  output logic watchdog_clear_pulse,
  // Oscillator pad configuration
  output cpmc_pkg::cpmc_pad_t osc_pad
);

  cpmc_pkg::cpmc_state_t q;  // Registered state
  cpmc_pkg::cpmc_state_t d;  // Next state

  logic do_write;          // Write address and data both held
  logic [7:0] wbyte;       // Byte written, zero when lane 0 disabled
  logic [7:0] ar_idx;      // Read index
  logic ar_ok;             // Read address in range
  logic [7:0] rd_val;      // Read mux output
  logic rd_hit;            // Read index mapped
  logic div_wrap;          // Divider reaches its cycle boundary
  logic [6:0] div_last;    // Terminal count of the active divisor
  logic p0_change;         // Any port 0 pin moved
  logic p1_change;         // Any enabled port 1 pin moved
  logic [PORT_W-1:0] p1_moved;  // Per-pin port 1 change
  logic is_rc_src;         // Internal RC high-speed source

  // Port 1 wake gating per pin
  genvar gi;
  generate
    for (gi = 0; gi < PORT_W; gi++) begin : g_p1w
      assign p1_moved[gi] = (port1_in[gi] != q.p1_prev[gi]) & q.p1_wake[gi];
    end
  endgenerate

  // Only the low eight pins are stored for change detection
  assign p0_change = (port0_in[7:0] != q.p0_prev);
  assign p1_change = |p1_moved;
  assign is_rc_src = (q.src == cpmc_pkg::CPMC_SRC_RC) || (q.src == cpmc_pkg::CPMC_SRC_RC_RTC);

  // Divider terminal count: 127 for code 0 down to 0 for code 7
  assign div_last = 7'h7f >> q.div_act;
  assign div_wrap = (q.div_cnt >= div_last);

  // Bus decode
  assign do_write = q.aw_have && q.w_have && !q.bvalid;
  assign wbyte = q.w_lane0 ? q.w_data : 8'h00;
  assign ar_idx = s_axi_araddr[9:2];
  assign ar_ok = (s_axi_araddr[ADDR_W-1:10] == '0) && (s_axi_araddr[1:0] == 2'h0);

  // Read mux; write-only registers read as zero
  always_comb begin
    rd_val = 8'h00;
    rd_hit = 1'b1;
    case (ar_idx)
      `CPMC_IDX_WDT_KICK: rd_val = 8'h00;
      `CPMC_IDX_CLK_APPLY: rd_val = 8'h00;
      `CPMC_IDX_POWER_CTRL: rd_val = {q.smod, 3'h0, q.p2sel, q.gf0, q.stop, q.idle};
      `CPMC_IDX_MEM_WAIT: rd_val = {1'b0, q.fetch_wait, q.xwr_ext, q.xrd_wait};
      `CPMC_IDX_P1_WAKE: rd_val = q.p1_wake;
      `CPMC_IDX_CLK_DIV: rd_val = {5'h00, q.div_pend};
      `CPMC_IDX_RST_CAUSE: begin
        // Flags are hardware owned; supply levels are shown live
        rd_val = {q.cause, 2'h0, vdd_below_mid_flag, vdd_below_high_flag, 1'b0};
      end
      `CPMC_IDX_SOFT_RST: rd_val = {7'h00, q.soft_reset_request_armed};
      `CPMC_IDX_CLK_STATUS: rd_val = {q.apply_pend, q.src, q.mode == cpmc_pkg::CPMC_IDLE, q.div_act};
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // Next-state logic for the whole controller
  always_comb begin
    d = q;
    // Single-cycle strobes fall back each cycle
    d.soft_rst = 1'b0;
    d.wdt_clr = 1'b0;
    d.cpu_tick = 1'b0;
    d.periph_tick = 1'b0;
    d.mem_ready = 1'b0;

    // Write address channel: hold until the data joins it
    if (s_axi_awvalid && !q.aw_have) begin
      d.aw_have = 1'b1;
      d.aw_idx = s_axi_awaddr[9:2];
      d.aw_ok = (s_axi_awaddr[ADDR_W-1:10] == '0) && (s_axi_awaddr[1:0] == 2'h0);
    end
    // Write data channel, either order
    if (s_axi_wvalid && !q.w_have) begin
      d.w_have = 1'b1;
      d.w_data = s_axi_wdata[7:0];
      d.w_lane0 = s_axi_wstrb[0];
    end
    // Write response retires
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    // Read channel: one outstanding read, answered one cycle after the address
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !q.rvalid) begin
      d.rvalid = 1'b1;
      d.rdata = (ar_ok && rd_hit) ? rd_val : 8'h00;
      d.rresp = (ar_ok && rd_hit) ? `CPMC_RESP_OKAY : `CPMC_RESP_SLVERR;
    end

    // Port history always tracks so a change is seen exactly once
    d.p0_prev = port0_in[7:0];
    d.p1_prev = port1_in[7:0];

    // Clock divider runs unless the oscillator is stopped
    if (q.mode != cpmc_pkg::CPMC_STOP) begin
      if (div_wrap) begin
        d.div_cnt = 7'h00;
        d.periph_tick = 1'b1;
        d.cpu_tick = (q.mode == cpmc_pkg::CPMC_NORMAL);
        // A new divisor starts only after a whole old period, so no short pulse
        if (q.apply_pend) begin
          d.div_act = q.div_pend;
          d.apply_pend = 1'b0;
          d.div_cnt = 7'h00;
        end
      end else begin
        d.div_cnt = q.div_cnt + 7'h01;
      end
    end

    // Memory wait counter counts CPU clock periods
    if (q.mem_busy) begin
      if (d.cpu_tick) begin
        if (q.mem_cnt == 4'h0) begin
          d.mem_busy = 1'b0;
          d.mem_ready = 1'b1;
        end else begin
          d.mem_cnt = q.mem_cnt - 4'h1;
        end
      end
    end else if (q.mode == cpmc_pkg::CPMC_NORMAL && !q.mem_ready) begin
      // The request level still stands at the edge that shows ready, so that edge takes nothing new
      // Fetch has priority, then external reads, then writes
      if (fetch_req) begin
        d.mem_busy = 1'b1;
        d.mem_cnt = {1'b0, q.fetch_wait};
      end else if (external_data_ram_rd_req) begin
        d.mem_busy = 1'b1;
        d.mem_cnt = {1'b0, q.xrd_wait};
      end else if (external_data_ram_wr_req) begin
        d.mem_busy = 1'b1;
        d.mem_cnt = {3'h0, q.xwr_ext};
      end
    end

    // Register writes
    if (do_write) begin
      d.aw_have = 1'b0;
      d.w_have = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = `CPMC_RESP_OKAY;
      // Any write but a one to the soft reset bit breaks the pair
      d.soft_reset_request_armed = 1'b0;
      if (!q.aw_ok) begin
        d.bresp = `CPMC_RESP_SLVERR;
      end else begin
        case (q.aw_idx)
          `CPMC_IDX_WDT_KICK: begin
            d.wdt_clr = (wbyte == `CPMC_KICK_CODE);
          end
          `CPMC_IDX_POWER_CTRL: begin
            d.smod = wbyte[`CPMC_PC_SMOD_BIT];
            d.p2sel = wbyte[`CPMC_PC_P2SEL_BIT];
            d.gf0 = wbyte[`CPMC_PC_GF0_BIT];
            d.stop = wbyte[`CPMC_PC_STOP_BIT];
            d.idle = wbyte[`CPMC_PC_IDLE_BIT];
          end
          `CPMC_IDX_MEM_WAIT: begin
            d.fetch_wait = wbyte[6:4];
            d.xwr_ext = wbyte[`CPMC_MW_XWR_BIT];
            d.xrd_wait = wbyte[2:0];
          end
          `CPMC_IDX_P1_WAKE: d.p1_wake = wbyte;
          `CPMC_IDX_CLK_DIV: d.div_pend = wbyte[2:0];
          `CPMC_IDX_CLK_APPLY: begin
            // Other values are dropped without touching the divider
            if (wbyte == `CPMC_APPLY_CODE) begin
              d.apply_pend = 1'b1;
            end
          end
          `CPMC_IDX_SOFT_RST: begin
            if (wbyte[`CPMC_SOFT_RESET_REQUEST_BIT]) begin
              if (q.soft_reset_request_armed) begin
                d.soft_rst = 1'b1;
              end else begin
                d.soft_reset_request_armed = 1'b1;
              end
            end
          end
          default: d.bresp = `CPMC_RESP_SLVERR;
        endcase
      end
    end

    // Power-mode sequencer
    case (q.mode)
      cpmc_pkg::CPMC_CFG: begin
        // Oscillator choice is caught once, then held for good
        d.src = cpmc_pkg::cpmc_src_t'(clk_src_option);
        d.warm_cnt = `CPMC_WARM_LONG;
        d.mode = cpmc_pkg::CPMC_WARM_OSC;
      end
      cpmc_pkg::CPMC_WARM_OSC: begin
        if (q.warm_cnt <= 12'h001) begin
          d.warm_cnt = `CPMC_WARM_SLOW;
          d.mode = cpmc_pkg::CPMC_WARM_SLOW;
        end else begin
          d.warm_cnt = q.warm_cnt - 12'h001;
        end
      end
      cpmc_pkg::CPMC_WARM_SLOW: begin
        if (slow_rc_tick) begin
          if (q.warm_cnt <= 12'h001) begin
            d.mode = cpmc_pkg::CPMC_NORMAL;
            d.stop = 1'b0;
          end else begin
            d.warm_cnt = q.warm_cnt - 12'h001;
          end
        end
      end
      cpmc_pkg::CPMC_NORMAL: begin
        // A write takes effect the cycle after it lands; stop outranks idle
        if (q.stop) begin
          d.mode = cpmc_pkg::CPMC_STOP;
        end else if (q.idle) begin
          d.mode = cpmc_pkg::CPMC_IDLE;
        end
      end
      cpmc_pkg::CPMC_IDLE: begin
        if (p0_change || p1_change || irq_event) begin
          d.mode = cpmc_pkg::CPMC_NORMAL;
          d.idle = 1'b0;
        end
      end
      cpmc_pkg::CPMC_STOP: begin
        // Interrupts are ignored here; registers keep their contents
        if (p0_change || p1_change) begin
          d.warm_cnt = is_rc_src ? `CPMC_WARM_SHORT : `CPMC_WARM_LONG;
          d.mode = cpmc_pkg::CPMC_WARM_OSC;
        end
      end
      default: d.mode = cpmc_pkg::CPMC_CFG;
    endcase

    // A reset-source event restarts the full warm-up and records its cause
    if (lvd_reset_event || wdt_reset_event || pin_reset_event) begin
      d.cause = {lvd_reset_event, wdt_reset_event, pin_reset_event};
      d.mode = cpmc_pkg::CPMC_WARM_OSC;
      d.warm_cnt = `CPMC_WARM_LONG;
      d.stop = 1'b0;
      d.idle = 1'b0;
      d.mem_busy = 1'b0;
    end

    // Synchronous reset gives every field its defined value
    if (!aresetn) begin
      d = '0;
      d.mode = cpmc_pkg::CPMC_CFG;
      d.src = cpmc_pkg::CPMC_SRC_RC;
      d.div_pend = `CPMC_RST_DIV;
      d.div_act = `CPMC_RST_DIV;
      d.fetch_wait = `CPMC_RST_FETCH_WAIT;
      d.xrd_wait = `CPMC_RST_XRD_WAIT;
      d.p2sel = `CPMC_RST_P2SEL;
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    q <= d;
  end

  // Bus handshakes
  assign s_axi_awready = !q.aw_have;
  assign s_axi_wready = !q.w_have;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = {24'h000000, q.rdata};
  assign s_axi_rresp = q.rresp;

  // Clock and power outputs
  assign cpu_clk_en = q.cpu_tick;
  assign periph_clk_en = q.periph_tick;
  assign osc_run = (q.mode != cpmc_pkg::CPMC_STOP);
  assign cpu_hold = (q.mode != cpmc_pkg::CPMC_NORMAL);
  assign mem_ready = q.mem_ready;
  assign soft_reset_pulse = q.soft_rst;
  assign watchdog_clear_pulse = q.wdt_clr;

  // Pad roles follow the latched oscillator choice
  assign osc_pad.osc_in_gpio = (q.src == cpmc_pkg::CPMC_SRC_RC);
  assign osc_pad.osc_out_gpio = (q.src == cpmc_pkg::CPMC_SRC_RC) || (q.src == cpmc_pkg::CPMC_SRC_EXT);
  assign osc_pad.xtal_drive = (q.src == cpmc_pkg::CPMC_SRC_RC_RTC) || (q.src == cpmc_pkg::CPMC_SRC_XTAL_HI)
    || (q.src == cpmc_pkg::CPMC_SRC_XTAL_LO);
  assign osc_pad.rtc_clk_en = (q.src == cpmc_pkg::CPMC_SRC_RC_RTC);

endmodule  // cpmc_ctrl

// File: verification/cpmc_ctrl_checker.sv
// Concurrent checks on the ports of the clock and power-mode controller
`timescale 1ns/10ps

module cpmc_ctrl_checker (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus responses
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Clock enables and power state
  input wire logic cpu_clk_en,
  input wire logic periph_clk_en,
  input wire logic osc_run,
  input wire logic cpu_hold,
  // Request pulses
  input wire logic soft_reset_pulse,
  input wire logic watchdog_clear_pulse
);
  logic [11:0] cnt_q; // Cycles since reset release, saturating

  // Count from release so the warm-up hold can be checked without a long repetition
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 12'h000;
    end else if (cnt_q != 12'hfff) begin
      cnt_q <= cnt_q + 12'h001;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_soft_reset_request_single: assert property (soft_reset_pulse |=> !soft_reset_pulse)
    else $error("soft reset pulse longer than one cycle");
  chk_kick_single: assert property (watchdog_clear_pulse |=> !watchdog_clear_pulse)
    else $error("watchdog clear pulse longer than one cycle");
  chk_stop_gate: assert property (!osc_run && $past(!osc_run) |-> !cpu_clk_en && !periph_clk_en)
    else $error("clock enable pulsing in stop");
  chk_stop_hold: assert property (!osc_run |-> cpu_hold)
    else $error("cpu running while oscillator stopped");
  chk_hold_gate: assert property (cpu_hold && $past(cpu_hold) |-> !cpu_clk_en)
    else $error("cpu clock enable while held");
  chk_warm_reset: assert property (cnt_q < 12'h7f8 |-> cpu_hold)
    else $error("cpu released before warm-up");
  chk_bresp_stable: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  chk_rdata_stable: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  chk_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
endmodule // cpmc_ctrl_checker

// File: verification/cpmc_cpu_model.sv
// Behavioural CPU memory requester facing the controller's memory handshake
`timescale 1ns/10ps

module cpmc_cpu_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Command from the bench: 1 fetch, 2 data read, 3 data write
  input wire logic go,
  input wire logic [1:0] kind,
  // Controller side
  input wire logic cpu_clk_en,
  input wire logic mem_ready,
  output logic fetch_req,
  output logic external_data_ram_rd_req,
  output logic external_data_ram_wr_req,
  // Status to the bench
  output logic busy,
  output logic [7:0] pulses
);
  logic [1:0] age; // Edges since go; the request is taken one edge after it rises

  // Request is held until the ready edge; cpu pulses seen meanwhile are counted
  // Pulses shown before the first period after the take belong to no access, so they are skipped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      age <= 2'h0;
      busy <= 1'b0;
      pulses <= 8'h00;
      {fetch_req, external_data_ram_rd_req, external_data_ram_wr_req} <= 3'h0;
    end else if (go) begin
      age <= 2'h0;
      busy <= 1'b1;
      pulses <= 8'h00;
      {fetch_req, external_data_ram_rd_req, external_data_ram_wr_req} <= {kind == 2'h1, kind == 2'h2, kind == 2'h3};
    end else if (busy) begin
      if (age != 2'h2) begin
        age <= age + 2'h1;
      end
      if (cpu_clk_en && age == 2'h2) begin
        pulses <= pulses + 8'h01;
      end
      if (mem_ready) begin // Release only after the answer is taken
        busy <= 1'b0;
        {fetch_req, external_data_ram_rd_req, external_data_ram_wr_req} <= 3'h0;
      end
    end
  end
endmodule // cpmc_cpu_model

// File: verification/cpmc_ctrl_bench.sv
// Self-checking bench of the clock and power-mode controller
`timescale 1ns/10ps
`include "cpmc_regs.svh"

module cpmc_ctrl_bench;
  logic aclk = 1'b0, aresetn = 1'b0; // Clock and reset
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000; // Bus master signals
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [2:0] clk_src_option = 3'h0; // Internal RC source
  logic vdd_below_mid_flag = 1'b1, vdd_below_high_flag = 1'b0;
  logic lvd_reset_event = 1'b0, wdt_reset_event = 1'b0, pin_reset_event = 1'b0;
  logic slow_rc_tick = 1'b0, irq_event = 1'b0;
  logic [3:0] tick_div = 4'h0;
  logic [7:0] port0_in = 8'h00, port1_in = 8'h00;
  logic fetch_req, external_data_ram_rd_req, external_data_ram_wr_req, mem_ready, cpu_clk_en, periph_clk_en, osc_run, cpu_hold;
  logic soft_reset_pulse, watchdog_clear_pulse, go = 1'b0, busy;
  logic [1:0] kind = 2'h0;
  logic [7:0] pulses;
  cpmc_pkg::cpmc_pad_t osc_pad;
  logic [31:0] d;
  logic [1:0] r;
  int failures = 0, cmp_count = 0, cyc = 0, soft_reset_request_n = 0, wdt_n = 0, n, p;

  cpmc_ctrl i_cpmc_ctrl (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .clk_src_option, .vdd_below_mid_flag, .vdd_below_high_flag, .lvd_reset_event, .wdt_reset_event,
    .pin_reset_event, .slow_rc_tick, .port0_in, .port1_in, .irq_event, .fetch_req, .external_data_ram_rd_req, .external_data_ram_wr_req,
    .mem_ready, .cpu_clk_en, .periph_clk_en, .osc_run, .cpu_hold, .soft_reset_pulse, .watchdog_clear_pulse, .osc_pad);
  cpmc_cpu_model i_cpmc_cpu_model (.aclk, .aresetn, .go, .kind, .cpu_clk_en, .mem_ready, .fetch_req, .external_data_ram_rd_req,
    .external_data_ram_wr_req, .busy, .pulses);

  // 100 MHz clock
  initial begin
    forever #5 aclk = ~aclk;
  end

  // Slow RC tick every 16 cycles, pulse counters and hang guard
  always @(posedge aclk) begin
    tick_div <= tick_div + 4'h1;
    slow_rc_tick <= (tick_div == 4'hf);
    if (soft_reset_pulse === 1'b1) soft_reset_request_n++;
    if (watchdog_clear_pulse === 1'b1) wdt_n++;
    cyc++;
    if (cyc == 40000) begin
      failures++;
      wrap_up();
    end
  end

  function automatic logic [11:0] ad(input logic [7:0] i); // Byte address is four times the index
    return {2'b00, i, 2'b00};
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Address and data offered together, each released when taken
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Cycles until the cpu is released
  task automatic wait_run();
    n = 0;
    while (cpu_hold !== 1'b0) begin
      @(posedge aclk);
      n++;
    end
  endtask

  // Skip two enables so a switch has landed, then time one period
  task automatic per();
    p = 0;
    repeat (2) begin
      @(posedge aclk);
      while (cpu_clk_en !== 1'b1) @(posedge aclk);
    end
    do begin
      @(posedge aclk);
      p++;
    end while (cpu_clk_en !== 1'b1);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    wait_run();
    chk(n >= 2049 && n <= 2160, 1);
    chk(osc_pad, 4'b1100);
    rd(ad(`CPMC_IDX_MEM_WAIT)); chk(d, 8'h71);
    rd(ad(`CPMC_IDX_CLK_DIV)); chk(d, 8'h07);
    rd(ad(`CPMC_IDX_POWER_CTRL)); chk(d, 8'h08);
    rd(ad(`CPMC_IDX_SOFT_RST)); chk(d, 8'h00);
    rd(ad(`CPMC_IDX_RST_CAUSE)); chk(d & 8'h06, 8'h04);
    rd(12'h004);
    chk(r, `CPMC_RESP_SLVERR);
    chk(d, 32'h0);
    for (int i = 0; i < 3; i++) begin
      @(posedge aclk);
      {lvd_reset_event, wdt_reset_event, pin_reset_event} <= 3'b100 >> i;
      @(posedge aclk);
      {lvd_reset_event, wdt_reset_event, pin_reset_event} <= 3'b000;
      repeat (2) @(posedge aclk);
      wait_run();
      chk(n >= 2040, 1);
      rd(ad(`CPMC_IDX_RST_CAUSE)); chk(d & 8'he0, 8'h80 >> i);
    end
    wr(ad(`CPMC_IDX_WDT_KICK), `CPMC_KICK_CODE);
    wr(ad(`CPMC_IDX_WDT_KICK), 8'h5b);
    // One, zero, one, other register, one, one: only the last pair fires
    wr(ad(`CPMC_IDX_SOFT_RST), 8'h01);
    wr(ad(`CPMC_IDX_SOFT_RST), 8'h00);
    wr(ad(`CPMC_IDX_SOFT_RST), 8'h01);
    wr(ad(`CPMC_IDX_WDT_KICK), 8'h00);
    wr(ad(`CPMC_IDX_SOFT_RST), 8'h01);
    chk(soft_reset_request_n, 0);
    wr(ad(`CPMC_IDX_SOFT_RST), 8'h01);
    repeat (2) @(posedge aclk);
    chk(soft_reset_request_n, 1);
    chk(wdt_n, 1);
    chk(r, `CPMC_RESP_OKAY);
    wr(12'h004, 8'h00);
    chk(r, `CPMC_RESP_SLVERR);
    wr(ad(`CPMC_IDX_CLK_DIV), 8'h03);
    wr(ad(`CPMC_IDX_CLK_APPLY), 8'h68);
    per(); chk(p, 1);
    // Internal RC source: firmware keeps the divider code at 101 or below
    for (int c = 0; c < 6; c++) begin
      wr(ad(`CPMC_IDX_CLK_DIV), c[7:0]);
      wr(ad(`CPMC_IDX_CLK_APPLY), `CPMC_APPLY_CODE);
      per(); chk(p, 128 >> c);
    end
    wr(ad(`CPMC_IDX_MEM_WAIT), 8'h2c);
    for (int k = 1; k < 4; k++) begin
      @(posedge aclk);
      kind <= k[1:0];
      go <= 1'b1;
      @(posedge aclk);
      go <= 1'b0;
      do @(posedge aclk); while (busy !== 1'b0);
      chk(pulses, (k == 1) ? 3 : (k == 2) ? 5 : 2);
    end
    wr(ad(`CPMC_IDX_POWER_CTRL), 8'h01);
    repeat (3) @(posedge aclk);
    chk({cpu_hold, osc_run}, 2'b11);
    port1_in <= 8'h01;
    repeat (3) @(posedge aclk);
    chk(cpu_hold, 1);
    wr(ad(`CPMC_IDX_P1_WAKE), 8'h01);
    port1_in <= 8'h00;
    repeat (3) @(posedge aclk);
    chk(cpu_hold, 0);
    rd(ad(`CPMC_IDX_POWER_CTRL)); chk(d & 8'h01, 0);
    wr(ad(`CPMC_IDX_POWER_CTRL), 8'h01);
    @(posedge aclk);
    chk(cpu_hold, 1);
    irq_event <= 1'b1;
    repeat (3) @(posedge aclk);
    irq_event <= 1'b0;
    chk(cpu_hold, 0);
    wr(ad(`CPMC_IDX_POWER_CTRL), 8'h02);
    repeat (3) @(posedge aclk);
    chk(osc_run, 0);
    irq_event <= 1'b1;
    repeat (3) @(posedge aclk);
    irq_event <= 1'b0;
    chk(osc_run, 0);
    port0_in <= 8'h10;
    wait_run();
    chk(n >= 64 && n <= 180, 1);
    rd(ad(`CPMC_IDX_POWER_CTRL)); chk(d & 8'h03, 0);
    wrap_up();
  end
endmodule // cpmc_ctrl_bench

bind cpmc_ctrl cpmc_ctrl_checker i_cpmc_ctrl_checker (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .cpu_clk_en, .periph_clk_en, .osc_run, .cpu_hold, .soft_reset_pulse,
  .watchdog_clear_pulse);
